// ===== inc/adsc_pkg.sv
// shared constants and types for the converter sequencer
package adsc_pkg;
    // widths
    localparam int RES_W = 10;
    localparam int CH_N  = 12;
    localparam int AW    = 16;
    localparam int DW    = 16;
    localparam int CNT_W = 9;
    // register offsets
    localparam logic [15:0] OFS_RESULT0 = 16'hfee0;
    localparam logic [15:0] OFS_TSS     = 16'hfedc;
    localparam logic [15:0] OFS_CSR     = 16'hfef8;
    localparam logic [15:0] OFS_CR      = 16'hfef9;
    localparam logic [15:0] OFS_XFER    = 16'hfefa;
    localparam logic [15:0] OFS_ISTAT   = 16'hfefc;
    localparam logic [15:0] OFS_IMASK   = 16'hfefd;
    // field positions
    localparam int CSR_END   = 7;
    localparam int CSR_IE    = 6;
    localparam int CSR_MODE  = 4;
    localparam int CSR_CH    = 0;
    localparam int CR_EXT_TRIGGER_ENABLE   = 7;
    localparam int CR_SPEED  = 6;
    localparam int CR_START  = 5;
    localparam int TSS_PIN   = 7;
    localparam int XFER_END  = 0;
    localparam int IRQ_W     = 3;
    localparam int IRQ_END   = 0;
    localparam int IRQ_TRIG  = 1;
    localparam int IRQ_MISS  = 2;
    // reset and fill values
    localparam logic [4:0]       CR_FILL  = 5'h1f;
    localparam logic [7:0]       TSS_RST  = 8'hff;
    localparam logic [RES_W-1:0] CODE_MSB = 10'h200;
    localparam logic [1:0]       GRP_LAST8  = 2'h1;
    localparam logic [1:0]       GRP_LAST12 = 2'h2;
    // timing in states, one state per system clock
    localparam int T_SYNC_SLOW = 10;
    localparam int T_SYNC_FAST = 6;
    localparam int T_SPL_SLOW  = 80;
    localparam int T_SPL_FAST  = 40;
    localparam int T_SCAN_SLOW = 256;
    localparam int T_SCAN_FAST = 128;
    localparam int T_BIT_SLOW  = 16;
    localparam int T_BIT_FAST  = 8;
    localparam int T_FIN_SLOW  = T_SCAN_SLOW - T_SPL_SLOW - RES_W * T_BIT_SLOW;
    localparam int T_FIN_FAST  = T_SCAN_FAST - T_SPL_FAST - RES_W * T_BIT_FAST;
    // scan mode field
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_SCAN4  = 2'h1,
        MODE_SCAN8  = 2'h2,
        MODE_SCAN12 = 2'h3
    } adsc_mode_t;
endpackage

// ===== inc/adsc_conv_if.sv
// handshake between sequencer and approximation engine
`timescale 1ns/100ps
interface adsc_conv_if;
    import adsc_pkg::*;
    logic             start;
    logic             with_sync;
    logic             fast;
    logic             abort;
    logic             busy;
    logic             done;
    logic [RES_W-1:0] result;
    modport ctrl (output start, with_sync, fast, abort, input busy, done, result);
    modport eng  (input start, with_sync, fast, abort, output busy, done, result);
endinterface

// ===== logic/adsc_sar.sv
// successive approximation engine with sync, sample and bit phases
`timescale 1ns/100ps
module adsc_sar (
    // system
    input  wire logic                   clock,
    input  wire logic                   reset,
    // sequencer
    adsc_conv_if.eng                    conv,
    // analog front end
    output logic                        sample_hold,
    output logic [adsc_pkg::RES_W-1:0]  dac_code,
    input  wire logic                   comparator_high
);
    import adsc_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_SAMPLE, ST_APPROX, ST_FINISH} adsc_eng_t;

    adsc_eng_t        state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [3:0]       bit_reg;
    logic [RES_W-1:0] code_reg;
    logic [RES_W-1:0] code_next;
    logic             last;

    // length of a phase for the selected speed, minus the given offset
    function automatic logic [CNT_W-1:0] pick(input logic fast, input int slow_v, input int fast_v, input int sub);
        return CNT_W'((fast ? fast_v : slow_v) - sub);
    endfunction

    assign last        = (cnt_reg == '0);
    assign conv.done   = (state_reg == ST_FINISH) && last;
    assign conv.busy   = (state_reg != ST_IDLE);
    assign conv.result = code_reg;
    assign dac_code    = code_reg;
    assign sample_hold = (state_reg == ST_SAMPLE);

    // phase sequencing
    always_ff @(posedge clock) begin
        if (reset || conv.abort) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            bit_reg   <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (conv.start && conv.with_sync) begin
                        state_reg <= ST_SYNC;
                        cnt_reg   <= pick(conv.fast, T_SYNC_SLOW, T_SYNC_FAST, 2);
                    end else if (conv.start) begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg   <= pick(conv.fast, T_SPL_SLOW, T_SPL_FAST, 1);
                    end
                end
                ST_SYNC: begin
                    if (last) begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg   <= pick(conv.fast, T_SPL_SLOW, T_SPL_FAST, 1);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (last) begin
                        state_reg <= ST_APPROX;
                        cnt_reg   <= pick(conv.fast, T_BIT_SLOW, T_BIT_FAST, 1);
                        bit_reg   <= 4'(RES_W - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_APPROX: begin
                    if (last && bit_reg == '0) begin
                        state_reg <= ST_FINISH;
                        cnt_reg   <= pick(conv.fast, T_FIN_SLOW, T_FIN_FAST, 1);
                    end else if (last) begin
                        bit_reg <= bit_reg - 1'b1;
                        cnt_reg <= pick(conv.fast, T_BIT_SLOW, T_BIT_FAST, 1);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_FINISH: begin
                    if (last && conv.start) begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg   <= pick(conv.fast, T_SPL_SLOW, T_SPL_FAST, 1);
                    end else if (last) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // keep or drop the trial bit, then try the next one
    always_comb begin
        code_next = code_reg;
        if (!comparator_high) begin
            code_next[bit_reg] = 1'b0;
        end
        if (bit_reg != '0) begin
            code_next[bit_reg - 1'b1] = 1'b1;
        end
    end

    // trial code
    always_ff @(posedge clock) begin
        if (reset) begin
            code_reg <= '0;
        end else if (state_reg == ST_SAMPLE && last) begin
            code_reg <= CODE_MSB;
        end else if (state_reg == ST_APPROX && last) begin
            code_reg <= code_next;
        end
    end
endmodule

// ===== logic/adsc_trig.sv
// external pin and timer match start detection
`timescale 1ns/100ps
module adsc_trig (
    // system
    input  wire logic clock,
    input  wire logic reset,
    // sources
    input  wire logic trigger_pin,
    input  wire logic timer_match,
    // control
    input  wire logic ext_enable,
    input  wire logic pin_source,
    input  wire logic start_flag,
    // results
    output logic      fire,
    output logic      missed
);
    logic pin_reg;
    logic pin_prev_reg;
    logic source;

    // pin sample and its previous value, idle high
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_reg      <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            pin_reg      <= trigger_pin;
            pin_prev_reg <= pin_reg;
        end
    end

    // falling edge, or timer match when the pin is deselected
    assign source = pin_source ? (pin_prev_reg && !pin_reg) : timer_match;
    assign fire   = ext_enable && source && !start_flag;
    assign missed = ext_enable && source && start_flag;
endmodule

// ===== logic/adsc_top.sv
// converter sequencer: registers, channel scan, flags and triggers
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module adsc_top (
    // system
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic                      standby,
    // register port
    input  wire logic [adsc_pkg::AW-1:0]   reg_addr,
    input  wire logic [adsc_pkg::DW-1:0]   reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [adsc_pkg::DW-1:0]        reg_rdata,
    // start sources
    input  wire logic                      shared_port_pin,
    input  wire logic                      timer_compare_match,
    output logic                           pin_is_trigger,
    // interrupt and transfer controller
    output logic                           conversion_end_irq,
    output logic                           xfer_req,
    input  wire logic                      xfer_started,
    output logic                           irq,
    // analog front end
    output logic [3:0]                     analog_channel,
    output logic                           sample_hold,
    output logic [adsc_pkg::RES_W-1:0]     dac_code,
    input  wire logic                      comparator_high
);
    import adsc_pkg::*;

    adsc_conv_if conv ();

    // control and status state
    logic             sys_reset;
    logic             end_reg;
    logic             ie_reg;
    adsc_mode_t       mode_reg;
    logic [3:0]       chsel_reg;
    logic             ext_trigger_enable_reg;
    logic             speed_reg;
    logic             start_reg;
    logic [7:0]       tss_reg;
    logic             xfer_en_reg;
    logic [IRQ_W-1:0] istat_reg;
    logic [IRQ_W-1:0] imask_reg;
    logic             armed_reg;
    logic [DW-1:0]    rdata_reg;
    logic [DW-1:0]    rdata_next;
    logic [RES_W-1:0] result_mem [CH_N];

    // sequencer state
    logic             active_reg;
    logic             done_q_reg;
    logic [1:0]       group_reg;
    logic [1:0]       idx_reg;
    logic [3:0]       chan_reg;
    logic [1:0]       group_next;
    logic [1:0]       idx_next;
    logic [1:0]       first_group;
    logic [1:0]       last_group;

    // decode
    logic             wr_csr;
    logic             wr_cr;
    logic             wr_tss;
    logic             wr_xfer;
    logic             wr_istat;
    logic             wr_imask;
    logic             rd_csr;
    logic             scan;
    logic             wrap;
    logic             launch;
    logic             chain;
    logic             fire;
    logic             missed;
    logic [IRQ_W-1:0] events;
    logic [4:0]       slot;

    // result register slot for an address: valid flag and channel
    function automatic logic [4:0] result_slot(input logic [AW-1:0] a);
        logic [AW-1:0] off;
        off = a - OFS_RESULT0;
        return {(off[0] == 1'b0) && (off[AW-1:1] < (AW-1)'(CH_N)), off[4:1]};
    endfunction

    assign sys_reset = reset || standby;

    // register strobes
    assign wr_csr   = reg_write && (reg_addr == OFS_CSR);
    assign wr_cr    = reg_write && (reg_addr == OFS_CR);
    assign wr_tss   = reg_write && (reg_addr == OFS_TSS);
    assign wr_xfer  = reg_write && (reg_addr == OFS_XFER);
    assign wr_istat = reg_write && (reg_addr == OFS_ISTAT);
    assign wr_imask = reg_write && (reg_addr == OFS_IMASK);
    assign rd_csr   = reg_read && (reg_addr == OFS_CSR);

    // start sources
    adsc_trig u_trig (
        .clock       (clock),
        .reset       (sys_reset),
        .trigger_pin (shared_port_pin),
        .timer_match (timer_compare_match),
        .ext_enable  (ext_trigger_enable_reg),
        .pin_source  (tss_reg[TSS_PIN]),
        .start_flag  (start_reg),
        .fire        (fire),
        .missed      (missed)
    );

    // approximation engine
    adsc_sar u_sar (
        .clock           (clock),
        .reset           (sys_reset),
        .conv            (conv.eng),
        .sample_hold     (sample_hold),
        .dac_code        (dac_code),
        .comparator_high (comparator_high)
    );

    // group bounds for the selected mode
    assign scan        = (mode_reg != MODE_SINGLE);
    assign first_group = (mode_reg == MODE_SCAN4) ? chsel_reg[3:2] : '0;
    always_comb begin
        case (mode_reg)
            MODE_SCAN8:  last_group = GRP_LAST8;
            MODE_SCAN12: last_group = GRP_LAST12;
            default:     last_group = chsel_reg[3:2];
        endcase
    end

    // next channel in ascending order
    assign wrap = (idx_reg == chsel_reg[1:0]) && (group_reg == last_group);
    always_comb begin
        idx_next   = idx_reg + 1'b1;
        group_next = group_reg;
        if (idx_reg == chsel_reg[1:0]) begin
            idx_next   = '0;
            group_next = wrap ? first_group : group_reg + 1'b1;
        end
    end

    // engine handshake
    assign launch         = start_reg && !active_reg && !conv.busy;
    assign chain          = conv.done && scan && start_reg;
    assign conv.start     = launch || chain;
    assign conv.with_sync = launch;
    assign conv.fast      = speed_reg;
    assign conv.abort     = active_reg && !start_reg;

    // run tracking
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            active_reg <= 1'b0;
        end else if (!start_reg) begin
            active_reg <= 1'b0;
        end else if (launch) begin
            active_reg <= 1'b1;
        end
    end

    // completion is flagged the cycle after the result lands
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            done_q_reg <= 1'b0;
        end else begin
            done_q_reg <= conv.done && (!scan || wrap);
        end
    end

    // channel position
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            group_reg <= '0;
            idx_reg   <= '0;
            chan_reg  <= '0;
        end else if (launch) begin
            group_reg <= first_group;
            idx_reg   <= '0;
            chan_reg  <= scan ? {first_group, 2'h0} : chsel_reg;
        end else if (chain) begin
            group_reg <= group_next;
            idx_reg   <= idx_next;
            chan_reg  <= {group_next, idx_next};
        end
    end
    assign analog_channel = chan_reg;

    // result registers
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            for (int i = 0; i < CH_N; i++) begin
                result_mem[i] <= '0;
            end
        end else if (conv.done && chan_reg < 4'(CH_N)) begin
            result_mem[chan_reg] <= conv.result;
        end
    end

    // start flag
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            start_reg <= 1'b0;
        end else if (fire) begin
            start_reg <= 1'b1;
        end else if (wr_cr) begin
            start_reg <= reg_wdata[CR_START];
        end else if (done_q_reg && !scan) begin
            start_reg <= 1'b0;
        end
    end

    // converter control fields
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            ext_trigger_enable_reg  <= 1'b0;
            speed_reg <= 1'b0;
        end else if (wr_cr) begin
            ext_trigger_enable_reg  <= reg_wdata[CR_EXT_TRIGGER_ENABLE];
            speed_reg <= reg_wdata[CR_SPEED];
        end
    end
    assign pin_is_trigger = ext_trigger_enable_reg;

    // mode, channel and irq enable fields
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            ie_reg    <= 1'b0;
            mode_reg  <= MODE_SINGLE;
            chsel_reg <= '0;
        end else if (wr_csr) begin
            ie_reg    <= reg_wdata[CSR_IE];
            mode_reg  <= adsc_mode_t'(reg_wdata[CSR_MODE +: 2]);
            chsel_reg <= reg_wdata[CSR_CH +: 4];
        end
    end

    // read of a set flag arms the clearing write
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            armed_reg <= 1'b0;
        end else if (rd_csr && end_reg) begin
            armed_reg <= 1'b1;
        end else if (wr_csr || !end_reg) begin
            armed_reg <= 1'b0;
        end
    end

    // end flag, setting wins over clearing
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            end_reg <= 1'b0;
        end else if (done_q_reg) begin
            end_reg <= 1'b1;
        end else if (xfer_started && xfer_en_reg) begin
            end_reg <= 1'b0;
        end else if (wr_csr && armed_reg && !reg_wdata[CSR_END]) begin
            end_reg <= 1'b0;
        end
    end

    // trigger source and transfer routing
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            tss_reg     <= TSS_RST;
            xfer_en_reg <= 1'b0;
        end else begin
            if (wr_tss) begin
                tss_reg <= reg_wdata[7:0];
            end
            if (wr_xfer) begin
                xfer_en_reg <= reg_wdata[XFER_END];
            end
        end
    end

    // end request goes to cpu or to the transfer unit
    assign conversion_end_irq = end_reg && ie_reg && !xfer_en_reg;
    assign xfer_req           = end_reg && ie_reg && xfer_en_reg;

    // sticky event status, write one to clear, set wins
    always_comb begin
        events           = '0;
        events[IRQ_END]  = done_q_reg;
        events[IRQ_TRIG] = fire;
        events[IRQ_MISS] = missed;
    end
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            istat_reg <= '0;
            imask_reg <= '0;
        end else begin
            istat_reg <= (istat_reg & ~(wr_istat ? reg_wdata[IRQ_W-1:0] : '0)) | events;
            if (wr_imask) begin
                imask_reg <= reg_wdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(istat_reg & imask_reg);

    // read data select
    always_comb begin
        rdata_next = '0;
        slot       = result_slot(reg_addr);
        if (slot[4]) begin
            rdata_next = DW'(result_mem[slot[3:0]]);
        end else begin
            case (reg_addr)
                OFS_CSR:   rdata_next = DW'({end_reg, ie_reg, mode_reg, chsel_reg});
                OFS_CR:    rdata_next = DW'({ext_trigger_enable_reg, speed_reg, start_reg, CR_FILL});
                OFS_TSS:   rdata_next = DW'(tss_reg);
                OFS_XFER:  rdata_next = DW'(xfer_en_reg);
                OFS_ISTAT: rdata_next = DW'(istat_reg);
                OFS_IMASK: rdata_next = DW'(imask_reg);
                default:   rdata_next = '0;
            endcase
        end
    end

    // read data stands for one cycle only
    always_ff @(posedge clock) begin
        if (sys_reset) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= reg_read ? rdata_next : '0;
        end
    end
    assign reg_rdata = rdata_reg;
endmodule

// ===== tb/adsc_top_asserts.sv
// port checker for the converter sequencer
`timescale 1ns/100ps
module adsc_top_asserts (
    // system
    input wire logic                     clock,
    input wire logic                     reset,
    // register port
    input wire logic [adsc_pkg::AW-1:0]  reg_addr,
    input wire logic [adsc_pkg::DW-1:0]  reg_wdata,
    input wire logic                     reg_write,
    input wire logic                     reg_read,
    input wire logic [adsc_pkg::DW-1:0]  reg_rdata,
    // requests and front end
    input wire logic                     pin_is_trigger,
    input wire logic                     conversion_end_irq,
    input wire logic                     xfer_req,
    input wire logic                     xfer_started,
    input wire logic [3:0]               analog_channel,
    input wire logic                     sample_hold,
    input wire logic [adsc_pkg::RES_W-1:0] dac_code
);
    import adsc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // request routing and transfer clearing
    a_route_excl: assert property (!(xfer_req && conversion_end_irq))
        else $error("end request on both routes");
    a_xfer_clear: assert property (xfer_started && xfer_req |=> !xfer_req)
        else $error("transfer start left flag set");
    // register side
    a_pin_follow: assert property (reg_write && reg_addr == OFS_CR |=> pin_is_trigger == $past(reg_wdata[CR_EXT_TRIGGER_ENABLE]))
        else $error("pin function not taken from write");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    // sampling timing and quiet outputs after reset
    a_sample_len: assert property ($rose(sample_hold) |-> ##[40:80] !sample_hold)
        else $error("sampling too long");
    a_chan_hold: assert property (sample_hold && $past(sample_hold) |-> $stable(analog_channel))
        else $error("channel moved while sampling");
    a_gap_min: assert property ($fell(sample_hold) |-> !sample_hold[*8])
        else $error("resample inside bit phase");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !xfer_req && !conversion_end_irq && !sample_hold
        && analog_channel == 4'h0 && dac_code == 10'h000)
        else $error("outputs active after reset");
endmodule

// ===== tb/adsc_afe_model.sv
// analog front end stand-in: fixed level per channel against trial code
`timescale 1ns/100ps
module adsc_afe_model (
    // from sequencer
    input  wire logic [3:0]                analog_channel,
    input  wire logic [adsc_pkg::RES_W-1:0] dac_code,
    // to sequencer
    output logic                           comparator_high
);
    import adsc_pkg::*;
    // level is channel number over a fixed low part
    assign comparator_high = {analog_channel, 6'h15} >= dac_code;
endmodule

// ===== tb/adsc_top_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module adsc_top_tb;
    import adsc_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        shared_port_pin = 1'b1;
    logic        timer_compare_match = 1'b0;
    logic        xfer_started = 1'b0;
    logic        standby = 1'b0;
    logic [15:0] reg_rdata;
    logic        pin_is_trigger, conversion_end_irq, xfer_req, irq, sample_hold, comparator_high;
    logic [3:0]  analog_channel;
    logic [9:0]  dac_code;
    logic [15:0] d;
    int          n;
    int          n_fail = 0;
    int          compares = 0;
    // device and analog stand-in
    adsc_top dut_u (.clock(clock), .reset(reset), .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .shared_port_pin(shared_port_pin),
        .timer_compare_match(timer_compare_match), .pin_is_trigger(pin_is_trigger),
        .conversion_end_irq(conversion_end_irq), .xfer_req(xfer_req), .xfer_started(xfer_started), .irq(irq),
        .analog_channel(analog_channel), .sample_hold(sample_hold), .dac_code(dac_code),
        .comparator_high(comparator_high));
    adsc_afe_model afe_u (.analog_channel(analog_channel), .dac_code(dac_code), .comparator_high(comparator_high));
    // verdict and end of run
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // register bus cycles
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(nm, exp, reg_rdata);
    endtask
    // bounded wait on end request (0) or transfer request (1)
    task automatic wt(input int sel, input int lim);
        n = 0;
        while ((sel == 0 ? conversion_end_irq : xfer_req) !== 1'b1) begin
            @(posedge clock);
            #1 n++;
            if (n > lim) begin
                n_fail++;
                complete_run();
            end
        end
    endtask
    // one pulse on pin, transfer start or timer match
    task automatic pulse(input int sel);
        @(posedge clock);
        if (sel == 0) shared_port_pin <= 1'b0;
        else if (sel == 1) xfer_started <= 1'b1;
        else timer_compare_match <= 1'b1;
        repeat (sel == 0 ? 3 : 1) @(posedge clock);
        shared_port_pin <= 1'b1;
        xfer_started <= 1'b0;
        timer_compare_match <= 1'b0;
    endtask
    initial begin
        forever #4 clock = ~clock;
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rc("cr_rst", OFS_CR, 16'h001f);
        rc("tss_rst", OFS_TSS, 16'h00ff);
        rc("unmapped", 16'hfe00, 16'h0000);
        wr(OFS_IMASK, 16'h0001);
        wr(OFS_CSR, 16'h0042);
        wr(OFS_CR, 16'h0020);
        rc("busy", OFS_CR, 16'h003f);
        wt(0, 400);
        chk("t_conv", 16'h0001, 16'(n >= 257 && n <= 266));
        chk("end_req", 16'h0003, {14'h0000, irq, conversion_end_irq});
        rc("single_end", OFS_CR, 16'h001f);
        rc("result2", OFS_RESULT0 + 16'h0004, {6'h00, 4'h2, 6'h15});
        wr(OFS_CSR, 16'h0042);
        rc("flag_kept", OFS_CSR, 16'h00c2);
        wr(OFS_CSR, 16'h0042);
        rc("flag_clr", OFS_CSR, 16'h0042);
        wr(OFS_IMASK, 16'h0000);
        #1 chk("irq_mask", 16'h0000, {15'h0000, irq});
        wr(OFS_ISTAT, 16'h0007);
        wr(OFS_IMASK, 16'h0007);
        #1 chk("irq_clr", 16'h0000, {15'h0000, irq});
        wr(OFS_CR, 16'h0080);
        #1 chk("pin_fn", 16'h0001, {15'h0000, pin_is_trigger});
        pulse(0);
        pulse(0);
        rc("trig_start", OFS_CR, 16'h00bf);
        wt(0, 400);
        rc("istat", OFS_ISTAT, 16'h0007);
        rc("flag_rd", OFS_CSR, 16'h00c2);
        wr(OFS_CSR, 16'h0042);
        wr(OFS_TSS, 16'h007f);
        pulse(0);
        rc("pin_ignored", OFS_CR, 16'h009f);
        pulse(2);
        rc("timer_start", OFS_CR, 16'h00bf);
        wt(0, 400);
        rc("flag_rd2", OFS_CSR, 16'h00c2);
        wr(OFS_CSR, 16'h0042);
        wr(OFS_XFER, 16'h0001);
        for (int m = 1; m <= 3; m++) begin
            wr(OFS_CSR, 16'h0041 | (16'(m) << 4));
            wr(OFS_CR, 16'h0060);
            wt(1, 1700);
            chk("first_grp", 16'(2 * m * T_SCAN_FAST + T_SYNC_FAST + 1), 16'(n));
            chk("route", 16'h0000, {15'h0000, conversion_end_irq});
            pulse(1);
            #1 chk("xfer_clr", 16'h0000, {15'h0000, xfer_req});
            rc("scan_on", OFS_CR, 16'h007f);
            wt(1, 1700);
            chk("period", 16'(2 * m * T_SCAN_FAST - 4), 16'(n));
            wr(OFS_CR, 16'h0040);
            rc("scan_off", OFS_CR, 16'h005f);
            pulse(1);
            rc("res_last", OFS_RESULT0 + 16'(8 * m - 6), {6'h00, 4'(4 * m - 3), 6'h15});
        end
        // standby acts as a mid-run reset of the registers
        @(posedge clock);
        standby <= 1'b1;
        @(posedge clock);
        standby <= 1'b0;
        rc("standby_tss", OFS_TSS, 16'h00ff);
        rc("standby_cr", OFS_CR, 16'h001f);
        complete_run();
    end
endmodule
bind adsc_top adsc_top_asserts chk_u (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_is_trigger(pin_is_trigger),
    .conversion_end_irq(conversion_end_irq), .xfer_req(xfer_req), .xfer_started(xfer_started),
    .analog_channel(analog_channel), .sample_hold(sample_hold), .dac_code(dac_code));
